// File: rtl/rtcec_pkg.sv
// Shared types and constants for the calendar clock entry, freeze, trim and wave block
// Assumes a single 50 MHz clock and a 32.768 kHz slow clock sampled as a pin
package rtcec_pkg;

   // Time word, AM/PM indicator at bit 22
   typedef struct packed {
      logic [8:0] pad_hi;
      logic pm;
      logic [5:0] hour;
      logic pad_h;
      logic [6:0] min;
      logic pad_m;
      logic [6:0] sec;
   } rtcec_time_t;

   // Calendar word
   typedef struct packed {
      logic [1:0] pad_hi;
      logic [5:0] date;
      logic [2:0] day;
      logic [4:0] month;
      logic [7:0] year;
      logic pad_c;
      logic [6:0] cent;
   } rtcec_cal_t;

   typedef struct packed {
      logic calendar_freeze_request;
      logic time_freeze_request;
   } rtcec_ctrl_t;

   typedef enum logic [2:0] {
      RTCEC_WAVE_OFF = 3'b000,
      RTCEC_WAVE_1HZ = 3'b001,
      RTCEC_WAVE_32HZ = 3'b010,
      RTCEC_WAVE_64HZ = 3'b011,
      RTCEC_WAVE_512HZ = 3'b100,
      RTCEC_WAVE_ALM_TOGGLE = 3'b101,
      RTCEC_WAVE_ALM_FLAG = 3'b110,
      RTCEC_WAVE_PULSE = 3'b111
   } rtcec_wave_t;

   typedef struct packed {
      logic hour12;
      logic persian;
      logic trim_sign;
      logic wide_range_trim;
      logic [6:0] correction;
      rtcec_wave_t wave_a_source_select;
      rtcec_wave_t wave_b_source_select;
   } rtcec_mode_t;

   typedef struct packed {
      logic alarm_clear;
      logic tick_clear;
      logic ack_clear;
   } rtcec_clear_t;

   // Validity flag positions
   localparam int VLD_TIME = 0;
   localparam int VLD_CAL = 1;
   localparam int VLD_TALM = 2;
   localparam int VLD_CALM = 3;

   // Reset values
   localparam logic [31:0] TIME_RESET = 32'h0000_0000;
   localparam logic [31:0] CAL_RESET = 32'h0181_0720;
   localparam logic [31:0] TALM_RESET = 32'h0000_0000;
   localparam logic [31:0] CALM_RESET = 32'h0101_0000;

   // Prescaler and trim
   localparam logic [15:0] SLOW_DIV = 16'h8000;
   localparam logic [15:0] TRIM_ADJ = 16'h0080;
   localparam logic [11:0] LOW_RANGE_MULT = 12'h014;
   localparam int TAP_1HZ = 14;
   localparam int TAP_32HZ = 9;
   localparam int TAP_64HZ = 8;
   localparam int TAP_512HZ = 5;

   // Pulse width, rounded down
   localparam int CLK_PERIOD_NS = 20;
   localparam int PULSE_US = 15;
   localparam logic [9:0] PULSE_CYC = 10'((PULSE_US * 1000) / CLK_PERIOD_NS);

   // Days in a month, as BCD
   function automatic logic [5:0] days_in_month(input logic [4:0] month, input logic [7:0] year,
                                                input logic persian);
      logic leap;
      leap = (!year[4] && (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8))
             || (year[4] && (year[3:0] == 4'h2 || year[3:0] == 4'h6));
      if (persian)
      begin
         days_in_month = (month <= 5'h06) ? 6'h31 : 6'h30;
      end
      else if (month == 5'h02)
      begin
         days_in_month = leap ? 6'h29 : 6'h28;
      end
      else if (month == 5'h04 || month == 5'h06 || month == 5'h09 || month == 5'h11)
      begin
         days_in_month = 6'h30;
      end
      else
      begin
         days_in_month = 6'h31;
      end
   endfunction

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9)
      begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end
      else
      begin
         bcd_inc = v + 8'h01;
      end
   endfunction

endpackage

// File: rtl/rtcec_entry_check.sv
// Entry check for one time word and one calendar word
// Assumes inputs come from logic on the same clock; purely combinational
`timescale 1ns/1ps
module rtcec_entry_check
   import rtcec_pkg::*;
(
   input wire rtcec_time_t time_in,
   input wire rtcec_cal_t cal_in,
   input wire logic hour12,
   input wire logic persian,
   output logic time_ok,
   output logic cal_ok
);

   function automatic logic bcd_ok(input logic [7:0] v);
      bcd_ok = (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
   endfunction

   logic hour_ok;
   logic date_ok;
   logic month_ok;
   logic cent_ok;

   assign hour_ok = bcd_ok({2'h0, time_in.hour}) &&
      (hour12 ? (time_in.hour >= 6'h01 && time_in.hour <= 6'h12)
              : (!time_in.pm && time_in.hour <= 6'h23));

   assign time_ok = hour_ok && bcd_ok({1'b0, time_in.min}) && time_in.min <= 7'h59 &&
      bcd_ok({1'b0, time_in.sec}) && time_in.sec <= 7'h59;

   assign cent_ok = persian ? (cal_in.cent == 7'h13 || cal_in.cent == 7'h14)
                            : (cal_in.cent == 7'h19 || cal_in.cent == 7'h20);

   assign month_ok = bcd_ok({3'h0, cal_in.month}) && cal_in.month >= 5'h01 && cal_in.month <= 5'h12;
   assign date_ok = bcd_ok({2'h0, cal_in.date}) && cal_in.date >= 6'h01 && cal_in.date <= 6'h31 &&
      cal_in.date <= days_in_month(cal_in.month, cal_in.year, persian);

   assign cal_ok = cent_ok && bcd_ok(cal_in.year) && month_ok && date_ok &&
      cal_in.day >= 3'h1 && cal_in.day <= 3'h7;

endmodule

// File: rtl/rtcec_core.sv
// Calendar clock core: entry check, freeze handshake, drift trim, two wave outputs
// Assumes control inputs on ref_clk; slow_clock is an unrelated pin
//
// Contract
// - Invalid write discarded, validity flag raised
// - Validity flag clears only on valid write
// - Century 19-20, or 13-14 when Persian
// - BCD year, month 01-12, date legal
// - Day of week 1 to 7
// - Hour range per 12/24 mode
// - Minutes, seconds BCD 00 to 59
// - AM/PM bit picks range; read 24-hour
// - Time freeze halts time and calendar
// - Calendar freeze halts calendar only
// - Trim spans 1.5 to 1950 ppm
// - Trim stretches or shrinks one second
// - Trim settings change on the fly
// - Two wave outputs, independent selectors
// - Selection zero holds low, releases pin
// - Selections 1-4 give 1/32/64/512 Hz
// - Selection 5 toggles on alarm
// - Selection 6 copies alarm flag
// - Selection 7 gives 15 us pulse
// - Correction zero disables trim
// - Trim sign sets divider below/above 32768
`timescale 1ns/1ps
module rtcec_core
   import rtcec_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic slow_clock,
   input wire rtcec_ctrl_t clock_control_reg,
   input wire rtcec_mode_t clock_mode_reg,
   input wire rtcec_clear_t status_clear_command,
   input wire logic alarm_event,
   input wire logic time_write,
   input wire rtcec_time_t time_wdata,
   input wire logic cal_write,
   input wire rtcec_cal_t cal_wdata,
   input wire logic talarm_write,
   input wire rtcec_time_t talarm_wdata,
   input wire logic calarm_write,
   input wire rtcec_cal_t calarm_wdata,
   output rtcec_time_t time_of_day_reg,
   output rtcec_cal_t calendar_reg,
   output rtcec_time_t time_alarm_reg,
   output rtcec_cal_t calendar_alarm_reg,
   output logic [3:0] valid_status,
   output logic freeze_acknowledge_flag,
   output logic one_hz_tick_flag,
   output logic alarm_flag,
   output logic wave_pin_a,
   output logic wave_pin_a_oe_n,
   output logic wave_pin_b,
   output logic wave_pin_b_oe_n
);

   // 12-hour BCD to 24-hour BCD
   function automatic logic [5:0] to_24h(input logic [5:0] hour, input logic pm, input logic hour12);
      logic [4:0] u;
      logic [1:0] t;
      u = {1'b0, hour[3:0]} + 5'h02;
      t = hour[5:4] + 2'h1;
      if (u > 5'h09)
      begin
         u = u - 5'h0A;
         t = t + 2'h1;
      end
      if (!hour12)
      begin
         to_24h = hour;
      end
      else if (hour == 6'h12)
      begin
         to_24h = pm ? 6'h12 : 6'h00;
      end
      else
      begin
         to_24h = pm ? {t, u[3:0]} : hour;
      end
   endfunction

   // Wave source mux
   function automatic logic wave_sel(input rtcec_wave_t sel, input logic [15:0] cnt, input logic tog,
                                     input logic flag, input logic pulse);
      unique case (sel)
         RTCEC_WAVE_OFF: wave_sel = 1'b0;
         RTCEC_WAVE_1HZ: wave_sel = cnt[TAP_1HZ];
         RTCEC_WAVE_32HZ: wave_sel = cnt[TAP_32HZ];
         RTCEC_WAVE_64HZ: wave_sel = cnt[TAP_64HZ];
         RTCEC_WAVE_512HZ: wave_sel = cnt[TAP_512HZ];
         RTCEC_WAVE_ALM_TOGGLE: wave_sel = tog;
         RTCEC_WAVE_ALM_FLAG: wave_sel = flag;
         RTCEC_WAVE_PULSE: wave_sel = pulse;
      endcase
   endfunction

   logic slow_sync1_r;
   logic slow_sync2_r;
   logic slow_prev_r;
   logic slow_tick;
   logic [15:0] div_cnt_r;
   logic [15:0] div_len;
   logic sec_tick;
   logic adjust_r;
   logic [11:0] trim_cnt_r;
   logic [11:0] trim_interval;
   rtcec_time_t time_r;
   rtcec_time_t time_wr24;
   rtcec_time_t talm_wr24;
   rtcec_cal_t cal_r;
   rtcec_cal_t calm_chk;
   rtcec_time_t talm_r;
   rtcec_cal_t calm_r;
   logic [3:0] valid_r;
   logic time_ok;
   logic cal_ok;
   logic talm_ok;
   logic calm_ok;
   logic time_halt;
   logic cal_halt;
   logic day_carry;
   logic req_any;
   logic req_any_r;
   logic ack_r;
   logic tick_flag_r;
   logic alarm_r;
   logic alarm_rise;
   logic [1:0] toggle_r;
   logic pulse_r;
   logic [9:0] pulse_cnt_r;
   logic wave_a_r;
   logic wave_b_r;
   logic oe_a_n_r;
   logic oe_b_n_r;

   // Slow clock pin synchroniser and edge
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         slow_sync1_r <= 1'b0;
         slow_sync2_r <= 1'b0;
         slow_prev_r <= 1'b0;
      end
      else
      begin
         slow_sync1_r <= slow_clock;
         slow_sync2_r <= slow_sync1_r;
         slow_prev_r <= slow_sync2_r;
      end
   end
   assign slow_tick = slow_sync2_r && !slow_prev_r;

   assign div_len = !adjust_r ? SLOW_DIV : (clock_mode_reg.trim_sign ? SLOW_DIV + TRIM_ADJ : SLOW_DIV - TRIM_ADJ);
   assign sec_tick = slow_tick && (div_cnt_r >= div_len - 16'h0001);

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         div_cnt_r <= 16'h0000;
      end
      else if (sec_tick)
      begin
         div_cnt_r <= 16'h0000;
      end
      else if (slow_tick)
      begin
         div_cnt_r <= div_cnt_r + 16'h0001;
      end
   end

   assign trim_interval = clock_mode_reg.wide_range_trim ? {5'h00, clock_mode_reg.correction} + 12'h001
      : ({5'h00, clock_mode_reg.correction} + 12'h001) * LOW_RANGE_MULT;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         trim_cnt_r <= 12'h000;
         adjust_r <= 1'b0;
      end
      else if (sec_tick)
      begin
         if (clock_mode_reg.correction == 7'h00)
         begin
            trim_cnt_r <= 12'h000;
            adjust_r <= 1'b0;
         end
         else if (trim_cnt_r >= trim_interval - 12'h001)
         begin
            trim_cnt_r <= 12'h000;
            adjust_r <= 1'b1;
         end
         else
         begin
            trim_cnt_r <= trim_cnt_r + 12'h001;
            adjust_r <= 1'b0;
         end
      end
   end

   always_comb
   begin
      time_wr24 = time_wdata;
      time_wr24.hour = to_24h(time_wdata.hour, time_wdata.pm, clock_mode_reg.hour12);
      time_wr24.pm = 1'b0;
      talm_wr24 = talarm_wdata;
      talm_wr24.hour = to_24h(talarm_wdata.hour, talarm_wdata.pm, clock_mode_reg.hour12);
      talm_wr24.pm = 1'b0;
      calm_chk = calarm_wdata;
      calm_chk.cent = 7'h20;
      calm_chk.year = 8'h00;
      calm_chk.day = 3'h1;
   end

   rtcec_entry_check u_check_cnt (
      .time_in(time_wdata),
      .cal_in(cal_wdata),
      .hour12(clock_mode_reg.hour12),
      .persian(clock_mode_reg.persian),
      .time_ok(time_ok),
      .cal_ok(cal_ok)
   );

   rtcec_entry_check u_check_alm (
      .time_in(talarm_wdata),
      .cal_in(calm_chk),
      .hour12(clock_mode_reg.hour12),
      .persian(1'b0),
      .time_ok(talm_ok),
      .cal_ok(calm_ok)
   );

   assign time_halt = clock_control_reg.time_freeze_request;
   assign cal_halt = clock_control_reg.time_freeze_request || clock_control_reg.calendar_freeze_request;
   assign day_carry = sec_tick && !time_halt && time_r.sec == 7'h59 && time_r.min == 7'h59 &&
      time_r.hour == 6'h23;

   // Time counters
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         time_r <= rtcec_time_t'(TIME_RESET);
      end
      else if (time_write && time_ok)
      begin
         time_r <= time_wr24;
      end
      else if (sec_tick && !time_halt)
      begin
         if (time_r.sec != 7'h59)
         begin
            time_r.sec <= 7'(bcd_inc({1'b0, time_r.sec}));
         end
         else
         begin
            time_r.sec <= 7'h00;
            if (time_r.min != 7'h59)
            begin
               time_r.min <= 7'(bcd_inc({1'b0, time_r.min}));
            end
            else
            begin
               time_r.min <= 7'h00;
               time_r.hour <= (time_r.hour == 6'h23) ? 6'h00 : 6'(bcd_inc({2'h0, time_r.hour}));
            end
         end
      end
   end

   // Calendar counters
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         cal_r <= rtcec_cal_t'(CAL_RESET);
      end
      else if (cal_write && cal_ok)
      begin
         cal_r <= cal_wdata;
      end
      else if (day_carry && !cal_halt)
      begin
         cal_r.day <= (cal_r.day == 3'h7) ? 3'h1 : cal_r.day + 3'h1;
         if (cal_r.date != days_in_month(cal_r.month, cal_r.year, clock_mode_reg.persian))
         begin
            cal_r.date <= 6'(bcd_inc({2'h0, cal_r.date}));
         end
         else
         begin
            cal_r.date <= 6'h01;
            if (cal_r.month != 5'h12)
            begin
               cal_r.month <= 5'(bcd_inc({3'h0, cal_r.month}));
            end
            else
            begin
               cal_r.month <= 5'h01;
               cal_r.year <= (cal_r.year == 8'h99) ? 8'h00 : bcd_inc(cal_r.year);
               if (cal_r.year == 8'h99)
               begin
                  cal_r.cent <= 7'(bcd_inc({1'b0, cal_r.cent}));
               end
            end
         end
      end
   end

   // Alarm registers
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         talm_r <= rtcec_time_t'(TALM_RESET);
         calm_r <= rtcec_cal_t'(CALM_RESET);
      end
      else
      begin
         if (talarm_write && talm_ok)
         begin
            talm_r <= talm_wr24;
         end
         if (calarm_write && calm_ok)
         begin
            calm_r <= calarm_wdata;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         valid_r <= 4'h0;
      end
      else
      begin
         if (time_write)
         begin
            valid_r[VLD_TIME] <= !time_ok;
         end
         if (cal_write)
         begin
            valid_r[VLD_CAL] <= !cal_ok;
         end
         if (talarm_write)
         begin
            valid_r[VLD_TALM] <= !talm_ok;
         end
         if (calarm_write)
         begin
            valid_r[VLD_CALM] <= !calm_ok;
         end
      end
   end

   assign req_any = clock_control_reg.time_freeze_request || clock_control_reg.calendar_freeze_request;
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         req_any_r <= 1'b0;
         ack_r <= 1'b0;
      end
      else
      begin
         req_any_r <= req_any;
         ack_r <= (req_any && !req_any_r) || (ack_r && !status_clear_command.ack_clear);
      end
   end

   // Tick and alarm flags, set wins
   assign alarm_rise = alarm_event && !alarm_r;
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         tick_flag_r <= 1'b0;
         alarm_r <= 1'b0;
      end
      else
      begin
         tick_flag_r <= sec_tick || (tick_flag_r && !status_clear_command.tick_clear);
         alarm_r <= alarm_event || (alarm_r && !status_clear_command.alarm_clear);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         toggle_r <= 2'h0;
      end
      else if (alarm_rise)
      begin
         toggle_r <= ~toggle_r;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         pulse_r <= 1'b0;
         pulse_cnt_r <= 10'h000;
      end
      else if (sec_tick)
      begin
         pulse_r <= 1'b1;
         pulse_cnt_r <= 10'h000;
      end
      else if (pulse_r)
      begin
         pulse_r <= (pulse_cnt_r != PULSE_CYC - 10'h001);
         pulse_cnt_r <= pulse_cnt_r + 10'h001;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         wave_a_r <= 1'b0;
         wave_b_r <= 1'b0;
         oe_a_n_r <= 1'b1;
         oe_b_n_r <= 1'b1;
      end
      else
      begin
         wave_a_r <= wave_sel(clock_mode_reg.wave_a_source_select, div_cnt_r, toggle_r[0] ^ alarm_rise,
                              alarm_event || (alarm_r && !status_clear_command.alarm_clear), pulse_r);
         wave_b_r <= wave_sel(clock_mode_reg.wave_b_source_select, div_cnt_r, toggle_r[1] ^ alarm_rise,
                              alarm_event || (alarm_r && !status_clear_command.alarm_clear), pulse_r);
         oe_a_n_r <= (clock_mode_reg.wave_a_source_select == RTCEC_WAVE_OFF);
         oe_b_n_r <= (clock_mode_reg.wave_b_source_select == RTCEC_WAVE_OFF);
      end
   end

   assign time_of_day_reg = time_r;
   assign calendar_reg = cal_r;
   assign time_alarm_reg = talm_r;
   assign calendar_alarm_reg = calm_r;
   assign valid_status = valid_r;
   assign freeze_acknowledge_flag = ack_r;
   assign one_hz_tick_flag = tick_flag_r;
   assign alarm_flag = alarm_r;
   assign wave_pin_a = wave_a_r;
   assign wave_pin_a_oe_n = oe_a_n_r;
   assign wave_pin_b = wave_b_r;
   assign wave_pin_b_oe_n = oe_b_n_r;

   AST_BAD_TIME_KEPT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      time_write && !time_ok && !sec_tick |=> $stable(time_r) && valid_r[VLD_TIME])
      else $error("invalid time write changed the time");
   AST_FLAG_STICKY: assert property (@(posedge ref_clk) disable iff (!rst_n)
      valid_r[VLD_CAL] && !(cal_write && cal_ok) |=> valid_r[VLD_CAL])
      else $error("calendar validity flag dropped without a valid write");
   AST_TIME_FROZEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clock_control_reg.time_freeze_request && !time_write && !cal_write |=> $stable(time_r) && $stable(cal_r))
      else $error("counters moved while time freeze requested");
   AST_CAL_FROZEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clock_control_reg.calendar_freeze_request && !cal_write |=> $stable(cal_r))
      else $error("calendar moved while calendar freeze requested");
   AST_ACK_ONCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(ack_r) |-> $past(req_any) && !$past(req_any_r))
      else $error("acknowledge raised without a new request");
   AST_SEL_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clock_mode_reg.wave_a_source_select == RTCEC_WAVE_OFF |=> !wave_pin_a && wave_pin_a_oe_n)
      else $error("wave a not held low with selection zero");
   AST_PULSE_WIDTH: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(pulse_r) |-> $past(pulse_cnt_r) == PULSE_CYC - 10'h001)
      else $error("second pulse has wrong width");
   AST_FLAG_COPY: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clock_mode_reg.wave_a_source_select == RTCEC_WAVE_ALM_FLAG ##1
      clock_mode_reg.wave_a_source_select == RTCEC_WAVE_ALM_FLAG |-> wave_pin_a == alarm_r)
      else $error("wave a does not follow the alarm flag");

endmodule

// File: testbench/rtcec_core_bench.sv
// Bench for rtcec_core: entry check rows, freeze handshake, wave outputs
// Assumes slow_clock is made here, one slow tick per 2 ref_clk cycles
`timescale 1ns/1ps
module rtcec_core_bench
   import rtcec_pkg::*;
;
   typedef struct packed {
      logic [1:0] kind;
      logic h12;
      logic per;
      logic ok;
      logic [31:0] data;
      logic [31:0] rb;
   } rtcec_row_t;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic slow_clock = 1'b0;
   rtcec_ctrl_t ctrl = '0;
   rtcec_mode_t mode = '0;
   rtcec_clear_t clr = '0;
   logic alarm_event = 1'b0;
   logic time_write = 1'b0;
   logic cal_write = 1'b0;
   logic talarm_write = 1'b0;
   logic calarm_write = 1'b0;
   rtcec_time_t time_wdata = '0;
   rtcec_time_t talarm_wdata = '0;
   rtcec_cal_t cal_wdata = '0;
   rtcec_cal_t calarm_wdata = '0;
   rtcec_time_t tod;
   rtcec_time_t talm;
   rtcec_cal_t cal;
   rtcec_cal_t calm;
   logic [3:0] valid_status;
   logic ack;
   logic tick;
   logic alarm_flag;
   logic pin_a;
   logic oe_a_n;
   logic pin_b;
   logic oe_b_n;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;
   int edges;
   logic prev;
   logic [3:0] vs = 4'h0;
   logic [31:0] expreg [0:3] = '{TIME_RESET, CAL_RESET, TALM_RESET, CALM_RESET};
   int taps [0:2] = '{TAP_32HZ, TAP_64HZ, TAP_512HZ};
   rtcec_row_t rows [0:19] = '{
      '{2'h0, 1'h0, 1'h0, 1'h1, 32'h00235959, 32'h00235959},
      '{2'h0, 1'h0, 1'h0, 1'h0, 32'h00240000, 32'h0},
      '{2'h0, 1'h0, 1'h0, 1'h0, 32'h00400000, 32'h0},
      '{2'h0, 1'h0, 1'h0, 1'h0, 32'h00006000, 32'h0},
      '{2'h0, 1'h0, 1'h0, 1'h0, 32'h0000005A, 32'h0},
      '{2'h0, 1'h1, 1'h0, 1'h1, 32'h00410000, 32'h00130000},
      '{2'h0, 1'h1, 1'h0, 1'h0, 32'h00000000, 32'h0},
      '{2'h0, 1'h1, 1'h0, 1'h0, 32'h00130000, 32'h0},
      '{2'h1, 1'h0, 1'h0, 1'h1, 32'h29622420, 32'h29622420},
      '{2'h1, 1'h0, 1'h0, 1'h0, 32'h29622320, 32'h0},
      '{2'h1, 1'h0, 1'h0, 1'h0, 32'h29622413, 32'h0},
      '{2'h1, 1'h0, 1'h1, 1'h0, 32'h31670113, 32'h0},
      '{2'h1, 1'h0, 1'h1, 1'h1, 32'h31660113, 32'h31660113},
      '{2'h1, 1'h0, 1'h0, 1'h0, 32'h01020120, 32'h0},
      '{2'h1, 1'h0, 1'h0, 1'h1, 32'h01E20120, 32'h01E20120},
      '{2'h1, 1'h0, 1'h0, 1'h0, 32'h32E10120, 32'h0},
      '{2'h1, 1'h0, 1'h0, 1'h0, 32'h01E11A20, 32'h0},
      '{2'h2, 1'h0, 1'h0, 1'h0, 32'h00006000, 32'h0},
      '{2'h2, 1'h0, 1'h0, 1'h1, 32'h00123456, 32'h00123456},
      '{2'h3, 1'h0, 1'h0, 1'h0, 32'h01130000, 32'h0}
   };

   rtcec_core u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .slow_clock(slow_clock), .clock_control_reg(ctrl),
      .clock_mode_reg(mode), .status_clear_command(clr), .alarm_event(alarm_event), .time_write(time_write),
      .time_wdata(time_wdata), .cal_write(cal_write), .cal_wdata(cal_wdata), .talarm_write(talarm_write),
      .talarm_wdata(talarm_wdata), .calarm_write(calarm_write), .calarm_wdata(calarm_wdata),
      .time_of_day_reg(tod), .calendar_reg(cal), .time_alarm_reg(talm), .calendar_alarm_reg(calm),
      .valid_status(valid_status), .freeze_acknowledge_flag(ack), .one_hz_tick_flag(tick),
      .alarm_flag(alarm_flag), .wave_pin_a(pin_a), .wave_pin_a_oe_n(oe_a_n), .wave_pin_b(pin_b),
      .wave_pin_b_oe_n(oe_b_n));

   always #10 ref_clk = ~ref_clk;

   always
   begin
      @(posedge ref_clk);
      #3 slow_clock = ~slow_clock;
   end

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         failures++;
         results();
      end
   end

   task automatic step;
      @(posedge ref_clk);
      #1;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         failures++;
      end
   endtask

   function automatic logic [31:0] reg_of(input logic [1:0] k);
      case (k)
         2'h0: reg_of = tod;
         2'h1: reg_of = cal;
         2'h2: reg_of = talm;
         default: reg_of = calm;
      endcase
   endfunction

   task automatic results;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
      begin
         $display("*** PASS ***");
      end
      else
      begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial
   begin
      repeat (8) step();
      rst_n = 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         chk("reset register", expreg[k], reg_of(2'(k)));
      end
      chk("reset flags", 32'h1, {valid_status, ack, tick, alarm_flag, pin_a, pin_b, oe_a_n & oe_b_n});
      // Table of entry writes
      foreach (rows[i])
      begin
         mode.hour12 = rows[i].h12;
         mode.persian = rows[i].per;
         time_wdata = rtcec_time_t'(rows[i].data);
         talarm_wdata = rtcec_time_t'(rows[i].data);
         cal_wdata = rtcec_cal_t'(rows[i].data);
         calarm_wdata = rtcec_cal_t'(rows[i].data);
         time_write = (rows[i].kind == 2'h0);
         cal_write = (rows[i].kind == 2'h1);
         talarm_write = (rows[i].kind == 2'h2);
         calarm_write = (rows[i].kind == 2'h3);
         step();
         {time_write, cal_write, talarm_write, calarm_write} = 4'h0;
         step();
         if (rows[i].ok)
         begin
            expreg[rows[i].kind] = rows[i].rb;
         end
         vs[rows[i].kind] = !rows[i].ok;
         chk("register", expreg[rows[i].kind], reg_of(rows[i].kind));
         chk("valid_status", {28'h0, vs}, {28'h0, valid_status});
      end
      mode = '0;
      // Freeze handshake, calendar first
      ctrl.calendar_freeze_request = 1'b1;
      step();
      chk("ack", 32'h1, {31'h0, ack});
      ctrl.time_freeze_request = 1'b1;
      clr.ack_clear = 1'b1;
      step();
      clr.ack_clear = 1'b0;
      repeat (3) step();
      chk("ack", 32'h0, {31'h0, ack});
      ctrl = '0;
      // Alarm driven selections
      mode.wave_a_source_select = RTCEC_WAVE_ALM_FLAG;
      mode.wave_b_source_select = RTCEC_WAVE_ALM_TOGGLE;
      for (int k = 0; k < 3; k++)
      begin
         if (k == 2)
         begin
            clr.alarm_clear = 1'b1;
            step();
            clr.alarm_clear = 1'b0;
            step();
            chk("pin_a", 32'h0, {31'h0, pin_a});
         end
         alarm_event = 1'b1;
         step();
         alarm_event = 1'b0;
         step();
         chk("pins", {29'h0, k != 2, 2'b00}, {29'h0, pin_b, oe_b_n, oe_a_n});
         chk("pin_a", 32'h1, {31'h0, pin_a});
      end
      mode.wave_b_source_select = RTCEC_WAVE_OFF;
      step();
      step();
      chk("pin_b off", 32'h1, {30'h0, pin_b, oe_b_n});
      // Prescaled square waves
      for (int k = 0; k < 3; k++)
      begin
         mode.wave_a_source_select = rtcec_wave_t'(3'h2 + 3'(k));
         step();
         step();
         edges = 0;
         prev = pin_a;
         repeat (8 * (2 << taps[k]))
         begin
            step();
            if (pin_a !== prev)
            begin
               edges++;
            end
            prev = pin_a;
         end
         chk("wave edges", 32'h8, 32'(edges));
      end
      // 1 Hz and pulse over a second
      mode.wave_a_source_select = RTCEC_WAVE_PULSE;
      mode.wave_b_source_select = RTCEC_WAVE_1HZ;
      step();
      step();
      edges = 0;
      prev = pin_b;
      while (tick !== 1'b1)
      begin
         step();
         edges += int'(pin_b !== prev);
         prev = pin_b;
      end
      step();
      edges += int'(pin_b !== prev);
      chk("1 Hz edges", 32'h2, 32'(edges));
      chk("time count", 32'h00130001, tod);
      edges = 0;
      while (pin_a === 1'b1 && edges < 800)
      begin
         step();
         edges++;
      end
      chk("pulse width", 32'(PULSE_CYC), 32'(edges));
      clr.tick_clear = 1'b1;
      step();
      clr.tick_clear = 1'b0;
      chk("tick clear", 32'h0, {31'h0, tick});
      results();
   end
endmodule
